// File: logic/mpsc_map.svh
// Overview of operation
// - Two-bit mode picks one of four product shifts: none, left one, left four, right six.
// - Product register is 32 bits and captures each full 16x16 product.
// - Scaler offers only left shifts of zero, one, four and right shift six.
// - Left shifts drop redundant sign bits; right shift guards accumulation against overflow.
// - Scaler sits between product and ALU or write bus, adding no latency.
// - A 16-bit operand register holds one multiply operand for the multiplier.
// - Variable-shift load, add and subtract take shift count from operand register.
// - Dynamic bit test takes the tested bit position from the operand register.
// - Multiplier finishes in one cycle, signed or unsigned, giving a 32-bit product.
// - ALU takes scaled operand from input scaler or product scaler, with accumulator.
`ifndef MPSC_MAP_SVH
`define MPSC_MAP_SVH
`define MPSC_MODE_RESET   2'h0
`define MPSC_LSH_ONE      1
`define MPSC_LSH_FOUR     4
`define MPSC_RSH_SIX      6
`define MPSC_PROD_RESET   32'h0000_0000
`define MPSC_OPND_RESET   16'h0000
`define MPSC_SHCNT_MSB    3
`define MPSC_BITPOS_MSB   3
`endif

// File: logic/mpsc_pkg.sv
`default_nettype none
package mpsc_pkg;
  typedef enum logic [1:0]
  {
    MPSC_PM_NONE  = 2'h0,
    MPSC_PM_LSH1  = 2'h1,
    MPSC_PM_LSH4  = 2'h2,
    MPSC_PM_RSH6  = 2'h3
  } mpsc_mode_e;
  typedef enum logic [1:0]
  {
    MPSC_SRC_INPUT   = 2'h1,
    MPSC_SRC_PRODUCT = 2'h2
  } mpsc_src_e;
endpackage
`default_nettype wire

// File: logic/mpsc_product_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_map.svh"
module mpsc_product_scaler
(
  // Product and mode
  input  wire logic [31:0] product_in,
  input  wire logic [1:0]  mode_in,
  // Scaled result
  output logic      [31:0] scaled_out
);
  always_comb
  begin
    case (mode_in)
      mpsc_pkg::MPSC_PM_NONE: scaled_out = product_in;
      mpsc_pkg::MPSC_PM_LSH1: scaled_out = product_in << `MPSC_LSH_ONE;
      mpsc_pkg::MPSC_PM_LSH4: scaled_out = product_in << `MPSC_LSH_FOUR;
      mpsc_pkg::MPSC_PM_RSH6: scaled_out = $signed(product_in) >>> `MPSC_RSH_SIX;
      default:                scaled_out = product_in;
    endcase
  end
endmodule
`default_nettype wire

// File: logic/mpsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_map.svh"
module mpsc_top
(
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SRST_IN,
  // Operand register load
  input  wire logic        OPND_LOAD_IN,
  input  wire logic [15:0] OPND_DATA_IN,
  // Multiply request
  input  wire logic        MULT_GO_IN,
  input  wire logic [15:0] MULT_OTHER_IN,
  input  wire logic        MULT_SIGNED_IN,
  // Mode field
  input  wire logic        MODE_LOAD_IN,
  input  wire logic [1:0]  MODE_DATA_IN,
  // Central ALU operand select
  input  wire logic [1:0]  ALU_SRC_IN,
  input  wire logic [31:0] INPUT_SCALED_IN,
  input  wire logic [31:0] ACC_IN,
  // Results
  output logic      [15:0] OPERAND_OUT,
  output logic      [31:0] PRODUCT_OUT,
  output logic      [31:0] SCALED_OUT,
  output logic      [31:0] ALU_OPERAND_OUT,
  output logic      [31:0] ALU_SUM_OUT,
  output logic      [1:0]  MODE_OUT,
  output logic      [3:0]  SHIFT_COUNT_OUT,
  output logic      [3:0]  BIT_POSITION_OUT
);

  logic        [15:0] multiplier_operand_register;
  logic        [31:0] product_register;
  logic        [1:0]  product_shift_mode;
  logic        [31:0] next_product;
  logic        [31:0] product_scaled;

  ////////////////////////////////////////////////////////////////////////////
  // Operand register
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
      multiplier_operand_register <= `MPSC_OPND_RESET;
    else if (OPND_LOAD_IN)
      multiplier_operand_register <= OPND_DATA_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-cycle multiplier
  always_comb
  begin
    if (MULT_SIGNED_IN)
      next_product = 32'($signed(multiplier_operand_register) * $signed(MULT_OTHER_IN));
    else
      next_product = 32'(multiplier_operand_register * MULT_OTHER_IN);
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
      product_register <= `MPSC_PROD_RESET;
    else if (MULT_GO_IN)
      product_register <= next_product;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode field
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
      product_shift_mode <= `MPSC_MODE_RESET;
    else if (MODE_LOAD_IN)
      product_shift_mode <= MODE_DATA_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Product scaler, combinational
  mpsc_product_scaler u_scaler
  (
    .product_in (product_register),
    .mode_in    (product_shift_mode),
    .scaled_out (product_scaled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb
  begin
    case (ALU_SRC_IN)
      mpsc_pkg::MPSC_SRC_PRODUCT: ALU_OPERAND_OUT = product_scaled;
      default:                    ALU_OPERAND_OUT = INPUT_SCALED_IN;
    endcase
  end

  assign ALU_SUM_OUT      = ACC_IN + ALU_OPERAND_OUT;
  assign SCALED_OUT       = product_scaled;
  assign OPERAND_OUT      = multiplier_operand_register;
  assign PRODUCT_OUT      = product_register;
  assign MODE_OUT         = product_shift_mode;
  assign SHIFT_COUNT_OUT  = multiplier_operand_register[`MPSC_SHCNT_MSB:0];
  assign BIT_POSITION_OUT = multiplier_operand_register[`MPSC_BITPOS_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_prod_hold;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    !MULT_GO_IN |=> $stable(PRODUCT_OUT);
  endproperty
  a_prod_hold: assert property (p_prod_hold) else $error("product changed unbidden");

  property p_signed_mul;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (MULT_GO_IN && MULT_SIGNED_IN) |=>
      $signed(PRODUCT_OUT) == $signed($past(OPERAND_OUT)) * $signed($past(MULT_OTHER_IN));
  endproperty
  a_signed_mul: assert property (p_signed_mul) else $error("signed product wrong");

  property p_unsigned_mul;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (MULT_GO_IN && !MULT_SIGNED_IN) |=>
      PRODUCT_OUT == 32'($past(OPERAND_OUT) * $past(MULT_OTHER_IN));
  endproperty
  a_unsigned_mul: assert property (p_unsigned_mul) else $error("unsigned product wrong");

  property p_rsh6;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    MODE_OUT == 2'h3 |-> SCALED_OUT == {{6{PRODUCT_OUT[31]}}, PRODUCT_OUT[31:6]};
  endproperty
  a_rsh6: assert property (p_rsh6) else $error("right shift six wrong");

  property p_lsh4;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    MODE_OUT == 2'h2 |-> SCALED_OUT == {PRODUCT_OUT[27:0], 4'h0};
  endproperty
  a_lsh4: assert property (p_lsh4) else $error("left shift four wrong");

  property p_lsh1_none;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (MODE_OUT == 2'h1 |-> SCALED_OUT == {PRODUCT_OUT[30:0], 1'h0}) and
    (MODE_OUT == 2'h0 |-> SCALED_OUT == PRODUCT_OUT);
  endproperty
  a_lsh1_none: assert property (p_lsh1_none) else $error("shift one or none wrong");

  property p_mode_hold;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    !MODE_LOAD_IN |=> $stable(MODE_OUT);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed unbidden");

  property p_mode_reset;
    @(posedge SYS_CLK_IN)
    SRST_IN |=> MODE_OUT == 2'h0;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not reset");

  property p_alu_src;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    ALU_SRC_IN == 2'h2 |-> ALU_SUM_OUT == ACC_IN + SCALED_OUT;
  endproperty
  a_alu_src: assert property (p_alu_src) else $error("alu sum wrong");

  property p_opnd_fields;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    OPND_LOAD_IN |=> SHIFT_COUNT_OUT == $past(OPND_DATA_IN[3:0]) &&
      BIT_POSITION_OUT == $past(OPND_DATA_IN[3:0]);
  endproperty
  a_opnd_fields: assert property (p_opnd_fields) else $error("operand fields wrong");

  property p_opnd_hold;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    !OPND_LOAD_IN |=>
      $stable(OPERAND_OUT);
  endproperty
  a_opnd_hold: assert property (p_opnd_hold) else $error("operand changed unbidden");

  property p_opnd_load;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    OPND_LOAD_IN |=>
      OPERAND_OUT == $past(OPND_DATA_IN);
  endproperty
  a_opnd_load: assert property (p_opnd_load) else $error("operand not loaded");

  property p_reset_clear;
    @(posedge SYS_CLK_IN)
    SRST_IN |=>
      OPERAND_OUT == `MPSC_OPND_RESET && PRODUCT_OUT == `MPSC_PROD_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");

  property p_mode_load;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    MODE_LOAD_IN |=>
      MODE_OUT == $past(MODE_DATA_IN);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

  property p_alu_input;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    ALU_SRC_IN != 2'h2 |->
      ALU_OPERAND_OUT == INPUT_SCALED_IN;
  endproperty
  a_alu_input: assert property (p_alu_input) else $error("alu operand wrong");

  property p_sum_input;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    ALU_SRC_IN != 2'h2 |->
      ALU_SUM_OUT == ACC_IN + INPUT_SCALED_IN;
  endproperty
  a_sum_input: assert property (p_sum_input) else $error("alu input sum wrong");

  property p_signed_sign;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (MULT_GO_IN && MULT_SIGNED_IN &&
      OPERAND_OUT != 16'h0000 && MULT_OTHER_IN != 16'h0000) |=>
      PRODUCT_OUT[31] == ($past(OPERAND_OUT[15]) ^ $past(MULT_OTHER_IN[15]));
  endproperty
  a_signed_sign: assert property (p_signed_sign) else $error("signed product sign wrong");

  c_rsh6: cover property (@(posedge SYS_CLK_IN) MODE_OUT == 2'h3 && PRODUCT_OUT[31]);
  c_mul_then_lsh4: cover property (@(posedge SYS_CLK_IN) MULT_GO_IN ##1 MODE_OUT == 2'h2);
  c_alu_product: cover property (@(posedge SYS_CLK_IN) ALU_SRC_IN == 2'h2 && MULT_GO_IN);
  c_signed_neg: cover property (@(posedge SYS_CLK_IN) MULT_GO_IN && MULT_SIGNED_IN && OPERAND_OUT[15]);
  c_lsh1: cover property (@(posedge SYS_CLK_IN) MODE_OUT == 2'h1 && PRODUCT_OUT[31]);

endmodule
`default_nettype wire

// File: bench/mpsc_alu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpsc_alu_model
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Accumulate request
  input  wire logic        acc_load_in,
  input  wire logic [15:0] data_in,
  input  wire logic [31:0] sum_in,
  // Toward the block
  output logic      [31:0] acc_out,
  output logic      [31:0] input_scaled_out
);
  // Input scaler fixed at left sixteen
  assign input_scaled_out = {data_in, 16'h0000};
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      acc_out <= 32'h0000_0000;
    else if (acc_load_in)
      acc_out <= sum_in;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, srst = 1'b1, old = 1'b0, go = 1'b0;
  logic        sgn = 1'b0, mld = 1'b0, ald = 1'b0;
  logic [15:0] opd = 16'h0000, oth = 16'h0000, isd = 16'h0000, opq;
  logic [1:0]  md = 2'h0, src = 2'h0, mdq;
  logic [31:0] acc, isc, prod, scl, aop, sum, pe;
  logic [3:0]  shc, bps;
  int          num_errors = 0;
  int          n_tests = 0;
  always #2.5 clk = ~clk;
  mpsc_top DUT (.SYS_CLK_IN(clk), .SRST_IN(srst), .OPND_LOAD_IN(old), .OPND_DATA_IN(opd),
    .MULT_GO_IN(go), .MULT_OTHER_IN(oth), .MULT_SIGNED_IN(sgn), .MODE_LOAD_IN(mld),
    .MODE_DATA_IN(md), .ALU_SRC_IN(src), .INPUT_SCALED_IN(isc), .ACC_IN(acc),
    .OPERAND_OUT(opq), .PRODUCT_OUT(prod), .SCALED_OUT(scl), .ALU_OPERAND_OUT(aop),
    .ALU_SUM_OUT(sum), .MODE_OUT(mdq), .SHIFT_COUNT_OUT(shc), .BIT_POSITION_OUT(bps));
  mpsc_alu_model PARTNER (.clk_in(clk), .srst_in(srst), .acc_load_in(ald), .data_in(isd),
    .sum_in(sum), .acc_out(acc), .input_scaled_out(isc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(negedge clk);
  endtask
  function automatic logic [31:0] scale(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << 4;
      default: return $signed(p) >>> 6;
    endcase
  endfunction
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    srst = 1'b1; old = 1'b1; opd = 16'h1234; go = 1'b1; mld = 1'b1; md = 2'h3;
    tick();
    srst = 1'b0; old = 1'b0; go = 1'b0; mld = 1'b0;
    check(32'(mdq), 32'h0);
    check(prod, 32'h0);
    check(32'(opq), 32'h0);
    check(scl, 32'h0);
    tick();
  endtask
  task automatic test_mult(input logic [15:0] a, input logic [15:0] b, input logic s);
    old = 1'b1; opd = a;
    tick();
    old = 1'b0; go = 1'b1; oth = b; sgn = s;
    check(32'(opq), 32'(a));
    tick();
    go = 1'b0;
    if (s)
      pe = $signed(a) * $signed(b);
    else
      pe = a * b;
    check(prod, pe);
    mld = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      md = 2'(m);
      tick();
      check(32'(mdq), 32'(m));
      check(scl, scale(pe, 2'(m)));
    end
    mld = 1'b0;
  endtask
  task automatic test_order();
    old = 1'b1; opd = 16'h1237;
    tick();
    opd = 16'h005c; go = 1'b1; oth = 16'h0002; sgn = 1'b0;
    tick();
    old = 1'b0; go = 1'b0;
    check(prod, 32'h0000_246e);
    check(32'(shc), 32'hc);
    check(32'(bps), 32'hc);
  endtask
  task automatic test_alu();
    logic [31:0] ae;
    logic [31:0] op;
    ae = 32'h0; isd = 16'h0012;
    for (int k = 0; k < 4; k++)
    begin
      src = 2'(k); ald = 1'b1;
      op = (k == 2) ? scale(32'h0000_246e, 2'h3) : 32'h0012_0000;
      #1;
      check(aop, op);
      check(sum, ae + op);
      tick();
      ae = ae + op;
    end
    ald = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) tick();
    test_reset();
    test_mult(16'h8001, 16'h7fff, 1'b1);
    test_mult(16'hfff0, 16'h0003, 1'b1);
    test_mult(16'hffff, 16'hffff, 1'b0);
    test_order();
    test_alu();
    test_reset();
    test_done();
  end
  initial
  begin
    #2000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
